// ===== logic/reset_seq_pkg.sv
package reset_seq_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int CNT_W = 21;
  localparam int N_FUNC = 4;
  localparam int N_ASYNC = 5;

  // Durations, typical figures, in their printed units
  localparam int DESTR_ST_TIME_MS = 60;
  localparam int DESTR_PLAIN_TIME_US = 400;
  localparam int EXT_LONG_TIME_MS = 60;
  localparam int FUNC_LONG_TIME_US = 300;
  localparam int FUNC_SHORT_TIME_US = 3;

  localparam int DESTR_ST_CYCLES = DESTR_ST_TIME_MS * (CLK_HZ / 1000);
  localparam int DESTR_PLAIN_CYCLES = DESTR_PLAIN_TIME_US * (CLK_HZ / 1_000_000);
  localparam int EXT_LONG_CYCLES = EXT_LONG_TIME_MS * (CLK_HZ / 1000);
  localparam int FUNC_LONG_CYCLES = FUNC_LONG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int FUNC_SHORT_CYCLES = FUNC_SHORT_TIME_US * (CLK_HZ / 1_000_000);

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_PIN_DRIVE = 8'h00;
  localparam logic [7:0] OFS_LENGTH_CFG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // Field positions
  localparam int LEN_PIN_SHORT_BIT = 4;
  localparam int ST_KIND_LSB = 0;
  localparam int ST_STATE_LSB = 4;
  localparam int ST_DRIVE_BIT = 8;
  localparam int ST_PIN_BIT = 9;
  localparam int ST_REG_MODE_BIT = 10;

  // Reset values
  localparam logic [N_FUNC-1:0] PIN_DRIVE_RST = 4'h0;
  localparam logic [N_FUNC-1:0] FUNC_LONG_RST = 4'hf;
  localparam logic PIN_SHORT_RST = 1'b0;
  // Async input order: 0 pin, 1 supervisor_n, 2 low-volt, 3 high-volt, 4 regulator mode
  localparam logic [N_ASYNC-1:0] SYNC_RST = 5'h03;

  typedef enum logic [2:0] {
    KIND_DESTR_SELFTEST = 3'b000,
    KIND_DESTR_PLAIN = 3'b001,
    KIND_EXT_LONG = 3'b010,
    KIND_FUNC_LONG = 3'b011,
    KIND_FUNC_SHORT = 3'b100
  } seq_kind_e;

  typedef enum logic [1:0] {
    ST_LAUNCH = 2'b00,
    ST_SEQ = 2'b01,
    ST_FINAL = 2'b10,
    ST_RUN = 2'b11
  } seq_state_e;

endpackage

// ===== logic/seq_timer.sv
`timescale 1ns/1ns
`default_nettype none
module seq_timer (
  input wire logic clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [reset_seq_pkg::CNT_W-1:0] load_val,
  output logic expired
);

  logic [reset_seq_pkg::CNT_W-1:0] cnt_q;
  logic run_q;
  logic last_w;

  assign last_w = (cnt_q == '0);

  // Expired rises exactly load_val+1 edges after load
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      expired <= 1'b0;
    end else if (load) begin
      cnt_q <= load_val;
      run_q <= 1'b1;
      expired <= 1'b0;
    end else if (run_q) begin
      if (last_w) begin
        run_q <= 1'b0;
        expired <= 1'b1;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ===== logic/reset_sequence_controller.sv
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Destructive sequence with self-test lasts 50 to 70 ms; 60 ms chosen.
// - Destructive sequence without self-test lasts 40 to 1000 us; 400 us chosen.
// - External long sequence with self-test lasts 50 to 70 ms; 60 ms chosen.
// - Functional long sequence lasts 40 to 600 us; 300 us chosen.
// - Functional short sequence lasts 1 to 10 us; 3 us chosen.
// - Sequence ends on entry to default run mode, first fetch allowed.
// - Reset pin is only pulled low; outside pullup makes the high level.
// - Pin held low externally keeps the device in the final reset phase.
// - Functional sequences drive the pin only if the source's drive enable is set.
// - Low or high voltage detectors start only destructive sequences.
// - Supervisor reset input starts destructive sequence in external regulator mode only.
// - Pin assertion starts a sequence only when running with pin released before.
// - Pin trigger: long plus self-test external long; long functional long; short functional short.
// - Functional sources start functional long or short per their own setting.
// - Pin level never gates or aborts destructive sequences, only extends them.
// - Self-test choice comes from nonvolatile shadow configuration input.
module reset_sequence_controller #(
  parameter int DESTR_ST_CYC = reset_seq_pkg::DESTR_ST_CYCLES,
  parameter int DESTR_PLAIN_CYC = reset_seq_pkg::DESTR_PLAIN_CYCLES,
  parameter int EXT_LONG_CYC = reset_seq_pkg::EXT_LONG_CYCLES,
  parameter int FUNC_LONG_CYC = reset_seq_pkg::FUNC_LONG_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  // Reset pin, open drain
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe_n,
  // Supervisor reset, active low
  input wire logic reset_sup_n,
  input wire logic low_voltage_detector,
  input wire logic high_voltage_detector,
  // High selects external voltage regulator mode
  input wire logic voltage_regulator_mode,
  // Shadow configuration: self-test enabled
  input wire logic selftest_cfg,
  input wire logic [reset_seq_pkg::N_FUNC-1:0] func_trig,
  output logic default_run_mode,
  output logic final_reset_phase,
  output logic [2:0] seq_kind,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [reset_seq_pkg::N_ASYNC-1:0] async_w;
  logic [reset_seq_pkg::N_ASYNC-1:0] sync1_q;
  logic [reset_seq_pkg::N_ASYNC-1:0] sync2_q;

  assign async_w = {voltage_regulator_mode, high_voltage_detector, low_voltage_detector,
                    reset_sup_n, reset_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < reset_seq_pkg::N_ASYNC; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          sync1_q[gi] <= reset_seq_pkg::SYNC_RST[gi];
          sync2_q[gi] <= reset_seq_pkg::SYNC_RST[gi];
        end else begin
          sync1_q[gi] <= async_w[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic pin_s;
  logic sup_n_s;
  logic low_volt_s;
  logic high_volt_s;
  logic ext_reg_mode_s;

  assign pin_s = sync2_q[0];
  assign sup_n_s = sync2_q[1];
  assign low_volt_s = sync2_q[2];
  assign high_volt_s = sync2_q[3];
  assign ext_reg_mode_s = sync2_q[4];

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [reset_seq_pkg::N_FUNC-1:0] reset_pin_drive_enable_reg_q;
  logic [reset_seq_pkg::N_FUNC-1:0] func_long_cfg_q;
  logic pin_short_cfg_q;

  logic wr_drive_w;
  logic wr_len_w;
  logic rd_drive_w;
  logic rd_len_w;
  logic rd_stat_w;

  assign wr_drive_w = reg_wr && (reg_addr == reset_seq_pkg::OFS_PIN_DRIVE);
  assign wr_len_w = reg_wr && (reg_addr == reset_seq_pkg::OFS_LENGTH_CFG);
  assign rd_drive_w = reg_rd && (reg_addr == reset_seq_pkg::OFS_PIN_DRIVE);
  assign rd_len_w = reg_rd && (reg_addr == reset_seq_pkg::OFS_LENGTH_CFG);
  assign rd_stat_w = reg_rd && (reg_addr == reset_seq_pkg::OFS_STATUS);

  always_ff @(posedge clk) begin
    if (srst) begin
      reset_pin_drive_enable_reg_q <= reset_seq_pkg::PIN_DRIVE_RST;
      func_long_cfg_q <= reset_seq_pkg::FUNC_LONG_RST;
      pin_short_cfg_q <= reset_seq_pkg::PIN_SHORT_RST;
    end else begin
      if (wr_drive_w) begin
        reset_pin_drive_enable_reg_q <= reg_wdata[reset_seq_pkg::N_FUNC-1:0];
      end
      if (wr_len_w) begin
        func_long_cfg_q <= reg_wdata[reset_seq_pkg::N_FUNC-1:0];
        pin_short_cfg_q <= reg_wdata[reset_seq_pkg::LEN_PIN_SHORT_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger decode

  reset_seq_pkg::seq_state_e state_q;
  reset_seq_pkg::seq_state_e state_d;
  reset_seq_pkg::seq_kind_e kind_q;
  reset_seq_pkg::seq_kind_e kind_d;
  logic drive_q;
  logic drive_d;
  logic pin_prev_q;

  logic destr_trig_w;
  logic pin_fall_w;
  logic func_any_w;
  logic [1:0] func_idx_w;
  logic func_long_w;
  logic func_drive_w;
  logic running_w;

  assign running_w = (state_q == reset_seq_pkg::ST_RUN);
  // Supervisor input ignored with internal regulator
  assign destr_trig_w = low_volt_s || high_volt_s || (ext_reg_mode_s && !sup_n_s);
  // Only a fall seen while running and released counts
  assign pin_fall_w = running_w && pin_prev_q && !pin_s;
  assign func_any_w = |func_trig;

  // Lowest numbered functional source wins
  always_comb begin
    func_idx_w = 2'd0;
    for (int i = reset_seq_pkg::N_FUNC - 1; i >= 0; i--) begin
      if (func_trig[i]) begin
        func_idx_w = 2'(i);
      end
    end
  end

  assign func_long_w = func_long_cfg_q[func_idx_w];
  assign func_drive_w = reset_pin_drive_enable_reg_q[func_idx_w];

  ////////////////////////////////////////////////////////////////////////////
  // Duration timer

  logic tmr_load_w;
  logic tmr_expired_w;
  logic [reset_seq_pkg::CNT_W-1:0] tmr_val_w;
  logic [reset_seq_pkg::CNT_W-1:0] cyc_w;

  always_comb begin
    case (kind_d)
      reset_seq_pkg::KIND_DESTR_SELFTEST: cyc_w = reset_seq_pkg::CNT_W'(DESTR_ST_CYC);
      reset_seq_pkg::KIND_DESTR_PLAIN: cyc_w = reset_seq_pkg::CNT_W'(DESTR_PLAIN_CYC);
      reset_seq_pkg::KIND_EXT_LONG: cyc_w = reset_seq_pkg::CNT_W'(EXT_LONG_CYC);
      reset_seq_pkg::KIND_FUNC_LONG: cyc_w = reset_seq_pkg::CNT_W'(FUNC_LONG_CYC);
      reset_seq_pkg::KIND_FUNC_SHORT: begin
        cyc_w = reset_seq_pkg::CNT_W'(reset_seq_pkg::FUNC_SHORT_CYCLES);
      end
      default: cyc_w = reset_seq_pkg::CNT_W'(DESTR_ST_CYC);
    endcase
  end

  // Loaded with N-2: one cycle of load plus N-1 countdown edges
  assign tmr_val_w = cyc_w - reset_seq_pkg::CNT_W'(2);
  assign tmr_load_w = (state_d == reset_seq_pkg::ST_SEQ) && (state_q != reset_seq_pkg::ST_SEQ);

  seq_timer u_timer (
    .clk(clk),
    .srst(srst),
    .load(tmr_load_w),
    .load_val(tmr_val_w),
    .expired(tmr_expired_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    drive_d = drive_q;
    if (destr_trig_w) begin
      // Restart from the top while any destructive source is active
      state_d = reset_seq_pkg::ST_LAUNCH;
      drive_d = 1'b1;
    end else begin
      case (state_q)
        reset_seq_pkg::ST_LAUNCH: begin
          // Self-test choice from shadow configuration
          kind_d = selftest_cfg ? reset_seq_pkg::KIND_DESTR_SELFTEST
                                : reset_seq_pkg::KIND_DESTR_PLAIN;
          drive_d = 1'b1;
          state_d = reset_seq_pkg::ST_SEQ;
        end
        reset_seq_pkg::ST_SEQ: begin
          // Pin level not looked at here
          if (tmr_expired_w) begin
            state_d = reset_seq_pkg::ST_FINAL;
            drive_d = 1'b0;
          end
        end
        reset_seq_pkg::ST_FINAL: begin
          // Held low outside: stay until released
          if (pin_s) begin
            state_d = reset_seq_pkg::ST_RUN;
          end
        end
        reset_seq_pkg::ST_RUN: begin
          if (pin_fall_w) begin
            state_d = reset_seq_pkg::ST_SEQ;
            if (pin_short_cfg_q) begin
              kind_d = reset_seq_pkg::KIND_FUNC_SHORT;
              drive_d = 1'b0;
            end else if (selftest_cfg) begin
              kind_d = reset_seq_pkg::KIND_EXT_LONG;
              drive_d = 1'b1;
            end else begin
              kind_d = reset_seq_pkg::KIND_FUNC_LONG;
              drive_d = 1'b0;
            end
          end else if (func_any_w) begin
            state_d = reset_seq_pkg::ST_SEQ;
            kind_d = func_long_w ? reset_seq_pkg::KIND_FUNC_LONG
                                 : reset_seq_pkg::KIND_FUNC_SHORT;
            drive_d = func_drive_w;
          end
        end
        default: begin
          state_d = reset_seq_pkg::ST_LAUNCH;
          drive_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= reset_seq_pkg::ST_LAUNCH;
      kind_q <= reset_seq_pkg::KIND_DESTR_SELFTEST;
      drive_q <= 1'b1;
      pin_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      drive_q <= drive_d;
      pin_prev_q <= pin_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Pin only ever pulled low, never driven high
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_n = !drive_q;
  assign default_run_mode = (state_q == reset_seq_pkg::ST_RUN);
  assign final_reset_phase = (state_q == reset_seq_pkg::ST_FINAL);
  assign seq_kind = kind_q;

  logic [31:0] status_w;
  logic [31:0] rdata_d;

  assign status_w = (32'(kind_q) << reset_seq_pkg::ST_KIND_LSB)
                  | (32'(state_q) << reset_seq_pkg::ST_STATE_LSB)
                  | (32'(drive_q) << reset_seq_pkg::ST_DRIVE_BIT)
                  | (32'(pin_s) << reset_seq_pkg::ST_PIN_BIT)
                  | (32'(ext_reg_mode_s) << reset_seq_pkg::ST_REG_MODE_BIT);

  assign rdata_d = rd_drive_w ? 32'(reset_pin_drive_enable_reg_q)
                 : rd_len_w ? (32'(func_long_cfg_q)
                              | (32'(pin_short_cfg_q) << reset_seq_pkg::LEN_PIN_SHORT_BIT))
                 : rd_stat_w ? status_w
                 : 32'h0000_0000;

  // Read data stand in the cycle after each cycle with the read strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule
`default_nettype wire

// ===== bench/reset_seq_checker_properties.sv
`timescale 1ns/1ns
`default_nettype none
module reset_seq_checker #(
  parameter int FUNC_LONG_CYC = 40,
  parameter int EXT_LONG_CYC = 150
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_pin_i,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_n,
  input wire logic reset_sup_n,
  input wire logic low_voltage_detector,
  input wire logic voltage_regulator_mode,
  input wire logic default_run_mode,
  input wire logic final_reset_phase,
  input wire logic [2:0] seq_kind
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////
  AST_PIN_NEVER_HIGH: assert property (reset_pin_o == 1'b0)
    else $error("reset pin output driven high");
  AST_RELEASE_AT_FINAL: assert property ($rose(final_reset_phase) |-> reset_pin_oe_n)
    else $error("pin still pulled at final phase");
  AST_HOLD_FINAL: assert property (
    final_reset_phase && !reset_pin_i |=> !default_run_mode)
    else $error("run entered while pin held low");
  AST_RUN_AFTER_RELEASE: assert property (
    (final_reset_phase && reset_pin_i) [*2] |-> ##[1:3] default_run_mode)
    else $error("run not entered after pin release");
  AST_DETECTOR_HOLDS: assert property (
    low_voltage_detector [*4] |-> !default_run_mode && !reset_pin_oe_n)
    else $error("detector did not hold destructive reset");
  AST_SUP_EXT_ONLY: assert property (
    (voltage_regulator_mode && !reset_sup_n) [*5] |-> !default_run_mode)
    else $error("supervisor reset ignored");
  AST_SHORT_LEN: assert property (
    $rose(final_reset_phase) && seq_kind == 3'd4 |->
    $past(default_run_mode, 76) && !$past(default_run_mode, 75))
    else $error("short sequence length wrong");
  AST_LONG_LEN: assert property (
    $rose(final_reset_phase) && seq_kind == 3'd3 |->
    $past(default_run_mode, FUNC_LONG_CYC + 1) && !$past(default_run_mode, FUNC_LONG_CYC))
    else $error("long sequence length wrong");
  AST_EXT_LEN: assert property (
    $rose(final_reset_phase) && seq_kind == 3'd2 |->
    $past(default_run_mode, EXT_LONG_CYC + 1) && !$past(default_run_mode, EXT_LONG_CYC))
    else $error("external sequence length wrong");
  cover property ($rose(final_reset_phase) && seq_kind == 3'd2);
  cover property (final_reset_phase && !reset_pin_i);
  cover property ($rose(default_run_mode));
endmodule

bind reset_sequence_controller reset_seq_checker #(
  .FUNC_LONG_CYC(FUNC_LONG_CYC),
  .EXT_LONG_CYC(EXT_LONG_CYC)
) reset_seq_checker_i (
  .clk(clk),
  .srst(srst),
  .reset_pin_i(reset_pin_i),
  .reset_pin_o(reset_pin_o),
  .reset_pin_oe_n(reset_pin_oe_n),
  .reset_sup_n(reset_sup_n),
  .low_voltage_detector(low_voltage_detector),
  .voltage_regulator_mode(voltage_regulator_mode),
  .default_run_mode(default_run_mode),
  .final_reset_phase(final_reset_phase),
  .seq_kind(seq_kind)
);
`default_nettype wire

// ===== bench/reset_supervisor_model.sv
`timescale 1ns/1ns
`default_nettype none
module reset_supervisor_model (
  input wire logic dev_oe_n,
  input wire logic hold_low,
  input wire logic sup_assert,
  output logic pin_level,
  output logic sup_n
);
  // Pullup gives high only when nobody pulls low
  assign pin_level = dev_oe_n & ~hold_low;
  assign sup_n = ~sup_assert;
endmodule
`default_nettype wire

// ===== bench/reset_sequence_controller_bench.sv
`timescale 1ns/1ns
`default_nettype none
module reset_sequence_controller_bench;
  localparam int DS = 200;
  localparam int DP = 50;
  localparam int EL = 150;
  localparam int FL = 40;
  localparam int FS = 75;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hold_low = 1'b0;
  logic sup_assert = 1'b0;
  logic low_volt = 1'b0;
  logic high_volt = 1'b0;
  logic ext_mode = 1'b0;
  logic st_cfg = 1'b1;
  logic [3:0] ftrig = 4'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wstb = 1'b0;
  logic rstb = 1'b0;
  logic pin, sup_n, oe_n, pin_o, run, fin;
  logic [2:0] kind;
  logic [31:0] rdata;
  int miscompares = 0;
  int samples_checked = 0;

  always #20 clk = ~clk;

  reset_supervisor_model reset_supervisor_model_i (.dev_oe_n(oe_n), .hold_low(hold_low),
    .sup_assert(sup_assert), .pin_level(pin), .sup_n(sup_n));
  reset_sequence_controller #(.DESTR_ST_CYC(DS), .DESTR_PLAIN_CYC(DP), .EXT_LONG_CYC(EL),
    .FUNC_LONG_CYC(FL)) reset_sequence_controller_i (.clk(clk), .srst(srst),
    .reset_pin_i(pin), .reset_pin_o(pin_o), .reset_pin_oe_n(oe_n), .reset_sup_n(sup_n),
    .low_voltage_detector(low_volt), .high_voltage_detector(high_volt),
    .voltage_regulator_mode(ext_mode),
    .selftest_cfg(st_cfg), .func_trig(ftrig), .default_run_mode(run),
    .final_reset_phase(fin), .seq_kind(kind), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wstb), .reg_rd(rstb), .reg_rdata(rdata));
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstb <= 1'b1;
    @(posedge clk);
    wstb <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    addr <= a;
    rstb <= 1'b1;
    @(posedge clk);
    rstb <= 1'b0;
    @(negedge clk);
    check(what, exp, rdata);
  endtask

  // Bounded wait; counts cycles until final phase
  task automatic to_final(output int n);
    n = 0;
    while (fin !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic wait_run();
    int i;
    i = 0;
    while (run !== 1'b1 && i < 2000) begin
      @(negedge clk);
      i++;
    end
    check("run mode", 1, run);
  endtask

  task automatic pulse(input logic [3:0] t);
    @(posedge clk);
    ftrig <= t;
    @(posedge clk);
    ftrig <= 4'h0;
  endtask

  task automatic seq(input string what, input logic [2:0] k, input int len, input logic drv);
    int n;
    logic low;
    n = 0;
    low = 1'b0;
    @(negedge clk);
    while (run === 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (fin !== 1'b1 && n < 2000) begin
      low = low | ~oe_n;
      @(negedge clk);
      n++;
    end
    check(what, k, kind);
    check("length", len, n);
    check("pin drive", drv, low);
    wait_run();
  endtask

  task automatic hold_pin(input int cyc);
    @(posedge clk);
    hold_low <= 1'b1;
    repeat (cyc) @(posedge clk);
    check("final hold", cyc > 100, fin);
    hold_low <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic power_up();
    int n;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    to_final(n);
    check("self-test length", 1, n >= DS && n <= DS + 2);
    check("power-up kind", 0, kind);
    wait_run();
    reg_read(8'h00, 32'h0000_0000, "drive enable reg");
    reg_read(8'h04, 32'h0000_000f, "length reg");
    reg_write(8'h08, 32'hffff_ffff);
    reg_write(8'h0c, 32'hffff_ffff);
    reg_read(8'h0c, 32'h0000_0000, "unmapped");
    reg_read(8'h08, 32'h0000_0230, "status");
  endtask

  task automatic func_seqs();
    reg_write(8'h00, 32'h0000_0009);
    reg_write(8'h04, 32'h0000_0006);
    pulse(4'h1);
    seq("short kind", 3'd4, FS, 1'b1);
    pulse(4'ha);
    seq("long kind", 3'd3, FL, 1'b0);
  endtask

  task automatic destr(input logic use_hvd);
    int n;
    pulse(4'h2);
    st_cfg <= 1'b0;
    repeat (10) @(posedge clk);
    low_volt <= ~use_hvd;
    high_volt <= use_hvd;
    // Low-volt case also holds the pin low outside: must not gate the sequence
    hold_low <= ~use_hvd;
    repeat (5) @(posedge clk);
    low_volt <= 1'b0;
    high_volt <= 1'b0;
    @(negedge clk);
    to_final(n);
    check("plain length", 1, n >= DP && n <= DP + 5);
    check("destructive kind", 1, kind);
    repeat (4) @(negedge clk);
    check("held final", !use_hvd, fin);
    @(posedge clk);
    hold_low <= 1'b0;
    wait_run();
  endtask

  task automatic pin_seqs();
    logic [2:0] k[3] = '{3'd2, 3'd3, 3'd4};
    int len[3] = '{EL, FL, FS};
    for (int i = 0; i < 3; i++) begin
      reg_write(8'h04, i == 2 ? 32'h0000_001f : 32'h0000_000f);
      st_cfg <= i == 0;
      fork
        seq("pin kind", k[i], len[i], i == 0);
        hold_pin(i == 0 ? EL + 30 : 6);
      join
    end
  endtask

  task automatic sup();
    @(posedge clk);
    sup_assert <= 1'b1;
    repeat (10) @(posedge clk);
    check("run kept", 1, run);
    sup_assert <= 1'b0;
    ext_mode <= 1'b1;
    repeat (4) @(posedge clk);
    sup_assert <= 1'b1;
    repeat (6) @(posedge clk);
    sup_assert <= 1'b0;
    @(negedge clk);
    check("run left", 0, run);
    wait_run();
    check("supervisor kind", 1, kind);
  endtask

  initial begin
    power_up();
    func_seqs();
    destr(1'b1);
    destr(1'b0);
    pin_seqs();
    sup();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
